/* File: verilog/urx_pkg.sv */
// urx_pkg: shared constants and carrier types for the receive status block
package urx_pkg;
	// ==========================================
	// register map (byte offsets)
	localparam logic [3:0] ADDR_RX_STATUS = 4'h0;
	localparam logic [3:0] ADDR_RX_DATA   = 4'h4;
	localparam logic [3:0] ADDR_BAUD_CTRL = 4'h8;
	// ==========================================
	// receive_status_control field positions
	localparam int RS_NINTH   = 0;
	localparam int RS_OVERRUN = 1;
	localparam int RS_FRAMING = 2;
	localparam int RS_ADDR    = 3;
	localparam int RS_RX_EN   = 4;
	localparam int RS_NINE_EN = 5;
	localparam int RS_PORT_EN = 7;
	// ==========================================
	// baud_rate_control field positions
	localparam int BC_ABD_OVF = 7;
	localparam int BC_IDLE    = 6;
	localparam int BC_POL     = 4;
	localparam int BC_WIDE    = 3;
	localparam int BC_WAKE    = 1;
	localparam int BC_ABD_EN  = 0;
	// ==========================================
	// reset values and sizes
	localparam logic [7:0] RESET_RX_STATUS = 8'h00;
	localparam logic [7:0] RESET_BAUD_CTRL = 8'h00;
	localparam int         FIFO_DEPTH      = 2;
	// ==========================================
	// one received character with its status
	typedef struct packed {
		logic       framing;
		logic       ninth;
		logic [7:0] data;
	} urx_char_t;
endpackage : urx_pkg

/* File: verilog/urx_sync.sv */
// urx_sync: three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module urx_sync
	import urx_pkg::*;
(
	// clock and reset
	input  wire logic clock_i,
	input  wire logic rstn_i,
	// asynchronous level in, filtered level out
	input  wire logic async_i,
	output var  logic level_o
);
	logic s1;
	logic s2;
	logic s3;
	// ==========================================
	// first stage read only by second stage
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			s1      <= 1'b1;
			s2      <= 1'b1;
			s3      <= 1'b1;
			level_o <= 1'b1;
		end else begin
			s1 <= async_i;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				level_o <= s3;
		end
	end
endmodule : urx_sync
`default_nettype wire

/* File: verilog/urx_fifo.sv */
// urx_fifo: two-entry receive character store with index pointers
`timescale 1ns/1ps
`default_nettype none
module urx_fifo
	import urx_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
)(
	// clock and reset
	input  wire logic      clock_i,
	input  wire logic      rstn_i,
	input  wire logic      flush_i,
	// fill side
	input  wire logic      push_i,
	input  wire urx_char_t wdata_i,
	// drain side
	input  wire logic      pop_i,
	output var  urx_char_t head_o,
	output var  logic      empty_o,
	output var  logic      full_o
);
	// elaboration check: one-bit pointers serve exactly two entries
	if (DEPTH != 2) begin : g_bad_depth
		$error("urx_fifo: depth must be 2");
	end
	urx_char_t  mem [DEPTH];
	logic       wr_ix;
	logic       rd_ix;
	logic [1:0] count;
	wire        do_push = push_i && (count != 2'h2);
	wire        do_pop  = pop_i && (count != 2'h0);
	// head is the oldest unread character with its own status
	assign head_o  = mem[rd_ix];
	assign empty_o = (count == 2'h0);
	assign full_o  = (count == 2'h2);
	// ==========================================
	// storage
	always_ff @(posedge clock_i) begin
		if (do_push)
			mem[wr_ix] <= wdata_i;
	end
	// pointers and fill count
	always_ff @(posedge clock_i) begin
		if (!rstn_i || flush_i) begin
			wr_ix <= 1'b0;
			rd_ix <= 1'b0;
			count <= 2'h0;
		end else begin
			if (do_push)
				wr_ix <= ~wr_ix;
			if (do_pop)
				rd_ix <= ~rd_ix;
			count <= count + {1'b0, do_push} - {1'b0, do_pop};
		end
	end
endmodule : urx_fifo
`default_nettype wire

/* File: verilog/urx_top.sv */
// urx_top: serial receive engine, status flags and baud control register
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module urx_top
	import urx_pkg::*;
#(
	parameter int BRG_W = 16
)(
	// clock and reset
	input  wire logic       clock_i,
	input  wire logic       rstn_i,
	// register port
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output var  logic [7:0] rdata_o,
	// serial line and mode
	input  wire logic       rx_pin_i,
	input  wire logic       sync_mode_i,
	input  wire logic [15:0] brg_div_i,
	input  wire logic       tx_data_i,
	// outputs
	output var  logic       tx_pin_o,
	output var  logic       sync_rising_o,
	output var  logic       rx_int_o
);
	// ==========================================
	// elaboration check: divisor, timer and autobaud paths are sixteen bits
	if (BRG_W != 16) begin : g_bad_brg_w
		$error("urx_top: baud generator width must be 16");
	end
	// receiver phases: waiting, start check, data bits, stop bit
	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} urx_state_t;
	// ==========================================
	// control and status registers
	// each is written through the register port, set or cleared by the
	// receiver itself, or both, as wake_en and abd_en are in one process
	logic        port_en;   // low holds the receiver in reset, all but wake detect
	logic        rx_enable; // continuous receive
	logic        nine_bit;  // nine data bits per character
	logic        addr_en;
	logic        overrun;
	logic        polarity;
	logic        wide;
	logic        wake_en;
	logic        abd_en;
	logic        abd_ovf;
	// ==========================================
	// receiver datapath and store view
	urx_state_t  state;
	logic [15:0] tick_cnt;
	logic [3:0]  bit_cnt;
	logic [8:0]  shift;
	logic        rx_prev;
	logic [15:0] abd_cnt;
	logic        rx_lvl;
	urx_char_t   head;
	logic        empty;
	logic        full;
	// ==========================================
	// address decode
	// a data read pops the store at the edge that registers its byte
	wire wr_status = wr_i && (addr_i == ADDR_RX_STATUS);
	wire wr_baud   = wr_i && (addr_i == ADDR_BAUD_CTRL);
	wire rd_data   = rd_i && (addr_i == ADDR_RX_DATA);
	wire rst_port  = !port_en;
	// ==========================================
	// bit timing
	// the counter runs down to zero and reloads, so a bit lasts divisor+1
	// clocks; the start edge loads half a bit, so later samples sit mid-bit
	// eight-bit generator uses the low byte only
	wire [15:0] divisor = wide ? brg_div_i : {8'h00, brg_div_i[7:0]};
	wire [15:0] half    = {1'b0, divisor[15:1]};
	wire        tick    = (tick_cnt == 16'h0000);
	wire        fall    = rx_prev && !rx_lvl;
	wire        async_m = !sync_mode_i;
	// ==========================================
	// character completion
	// bits enter at the top of shift, lsb first: eight leave the byte in
	// shift[8:1], nine fill it; the stop sample low marks a framing error
	wire        last_bit = (bit_cnt == (nine_bit ? 4'h8 : 4'h7));
	wire        done     = (state == ST_STOP) && tick;
	wire        frm_err  = !rx_lvl;
	wire [8:0]  nbits    = nine_bit ? shift : {1'b0, shift[8:1]};
	// storing needs room, no pending overrun and receive on; a character
	// finding the store full raises overrun and is lost, stored ones stay
	wire        accept   = !addr_en || (nine_bit && nbits[8]);
	wire        push     = done && accept && !overrun && !full && rx_enable;
	wire        ovf_set  = done && accept && full && rx_enable;
	// wake and autobaud act in asynchronous mode only; autobaud ends when
	// the line goes high again after a counted low stretch
	wire        wake_ev  = async_m && wake_en && fall && (state == ST_IDLE);
	wire        abd_done = async_m && abd_en && (state == ST_IDLE) && !fall && rx_lvl && (abd_cnt != 16'h0000)
		&& rx_prev;
	wire        abd_wrap = async_m && abd_en && (abd_cnt == 16'hFFFF);
	wire urx_char_t in_char = '{framing: frm_err, ninth: nbits[8], data: nbits[7:0]};
	// ==========================================
	// read data mux
	// framing and ninth bits show the oldest character, forced low when the store
	// is empty so stale entries never leak; unused bits read as zero
	// outside a read the bus returns zero, so a late sample shows nothing
	wire [7:0] status_rd = {port_en, 1'b0, nine_bit, rx_enable, addr_en, head.framing & !empty, overrun,
		head.ninth & !empty};
	wire [7:0] baud_rd = {abd_ovf & async_m, (state == ST_IDLE), 1'b0, polarity, wide, 1'b0,
		wake_en, abd_en};
	wire [7:0] next_rdata = !rd_i ? 8'h00 :
		(addr_i == ADDR_RX_STATUS) ? status_rd :
		(addr_i == ADDR_RX_DATA)   ? (empty ? 8'h00 : head.data) :
		(addr_i == ADDR_BAUD_CTRL) ? baud_rd : 8'h00;
	// ==========================================
	// line synchroniser and character store
	// the pin passes four flops, three stages and the filter, before the falling-edge detector sees it,
	// so a start bit is noticed about four clocks after it appears
	// port disable empties the store, which clears framing and ninth bit
	urx_sync u_sync (
		.clock_i (clock_i),
		.rstn_i  (rstn_i),
		.async_i (rx_pin_i),
		.level_o (rx_lvl)
	);
	urx_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
		.clock_i (clock_i),
		.rstn_i  (rstn_i),
		.flush_i (rst_port),
		.push_i  (push),
		.wdata_i (in_char),
		.pop_i   (rd_data),
		.head_o  (head),
		.empty_o (empty),
		.full_o  (full)
	);
	// ==========================================
	// software-written control bits
	// a write takes effect on the next cycle; read-only bits of the
	// written byte are ignored
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			{port_en, nine_bit, rx_enable, addr_en} <= {RESET_RX_STATUS[RS_PORT_EN],
				RESET_RX_STATUS[RS_NINE_EN], RESET_RX_STATUS[RS_RX_EN], RESET_RX_STATUS[RS_ADDR]};
		end else if (wr_status) begin
			port_en   <= wdata_i[RS_PORT_EN];
			nine_bit  <= wdata_i[RS_NINE_EN];
			rx_enable <= wdata_i[RS_RX_EN];
			addr_en   <= wdata_i[RS_ADDR];
		end
	end
	// overrun: set wins, cleared by receive or port disable
	// while receive stays off the flag is held low, so software may
	// clear it with one write and turn receive back on with the next
	always_ff @(posedge clock_i) begin
		if (!rstn_i)
			overrun <= 1'b0;
		else if (ovf_set)
			overrun <= 1'b1;
		else if (!rx_enable || rst_port)
			overrun <= 1'b0;
	end
	// baud control: polarity and width
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			polarity <= RESET_BAUD_CTRL[BC_POL];
			wide     <= RESET_BAUD_CTRL[BC_WIDE];
		end else if (wr_baud) begin
			polarity <= wdata_i[BC_POL];
			wide     <= wdata_i[BC_WIDE];
		end
	end
	// self-clearing enables: hardware clear wins over write
	// a write landing on the clearing cycle is lost, so software
	// should read the bit back before relying on it
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			wake_en <= RESET_BAUD_CTRL[BC_WAKE];
			abd_en  <= RESET_BAUD_CTRL[BC_ABD_EN];
		end else begin
			if (wake_ev)
				wake_en <= 1'b0;
			else if (wr_baud)
				wake_en <= wdata_i[BC_WAKE];
			if (abd_done)
				abd_en <= 1'b0;
			else if (wr_baud)
				abd_en <= wdata_i[BC_ABD_EN];
		end
	end
	// autobaud timer and overflow flag
	// counts clocks while the line is low; all ones flags overflow,
	// which stays until autobaud is armed again by software or the port is disabled
	always_ff @(posedge clock_i) begin
		if (!rstn_i || rst_port) begin
			abd_cnt <= 16'h0000;
			abd_ovf <= 1'b0;
		end else begin
			if (abd_en && async_m && !rx_lvl)
				abd_cnt <= abd_cnt + 16'h0001;
			else if (!abd_en)
				abd_cnt <= 16'h0000;
			if (abd_wrap)
				abd_ovf <= 1'b1;
			else if (wr_baud && wdata_i[BC_ABD_EN])
				abd_ovf <= 1'b0;
		end
	end
	// ==========================================
	// receive state machine, bit timing and shifting
	// a start is taken only while idle, receive on, no overrun and
	// autobaud off; a start sample that reads high is a glitch and
	// drops back to idle; the character is handed over at the stop
	// sample, so the remaining half stop bit overlaps the next wait
	// the tick counter free-runs in idle and is only reloaded with
	// half a bit by the start edge
	always_ff @(posedge clock_i) begin
		if (!rstn_i || rst_port) begin
			state    <= ST_IDLE;
			tick_cnt <= 16'h0000;
			bit_cnt  <= 4'h0;
			shift    <= 9'h000;
			rx_prev  <= 1'b1;
		end else begin
			rx_prev  <= rx_lvl;
			tick_cnt <= tick ? divisor : tick_cnt - 16'h0001;
			unique case (state)
				ST_IDLE: begin
					if (fall && rx_enable && !overrun && !abd_en) begin
						state    <= ST_START;
						tick_cnt <= half;
					end
				end
				ST_START: begin
					if (tick) begin
						state   <= rx_lvl ? ST_IDLE : ST_DATA;
						bit_cnt <= 4'h0;
					end
				end
				ST_DATA: begin
					if (tick) begin
						shift   <= {rx_lvl, shift[8:1]};
						bit_cnt <= bit_cnt + 4'h1;
						if (last_bit)
							state <= ST_STOP;
					end
				end
				ST_STOP: begin
					if (tick)
						state <= ST_IDLE;
				end
			endcase
		end
	end
	// ==========================================
	// registered outputs
	// the interrupt follows the store: it drops on the read that takes
	// the last character, stays through a read of one of two, and
	// rises the cycle after a push or a wake event
	// framing status alone never raises it
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			rdata_o       <= 8'h00;
			tx_pin_o      <= 1'b1;
			sync_rising_o <= 1'b0;
			rx_int_o      <= 1'b0;
		end else begin
			rdata_o       <= next_rdata;
			tx_pin_o      <= (async_m && polarity) ? ~tx_data_i : tx_data_i;
			sync_rising_o <= sync_mode_i && polarity;
			rx_int_o      <= (!empty && !(rd_data && !full)) || push || wake_ev;
		end
	end
endmodule : urx_top
`default_nettype wire

/* File: verification/urx_top_assertions.sv */
// urx_chk: port-level assertions for the receive status block
`timescale 1ns/1ps
`default_nettype none
module urx_chk
	import urx_pkg::*;
#(
	parameter int BRG_W = 16
)(
	// clock and reset
	input wire logic        clock_i,
	input wire logic        rstn_i,
	// register port
	input wire logic [3:0]  addr_i,
	input wire logic [7:0]  wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [7:0]  rdata_o,
	// line, mode and outputs
	input wire logic        rx_pin_i,
	input wire logic        sync_mode_i,
	input wire logic [15:0] brg_div_i,
	input wire logic        tx_data_i,
	input wire logic        tx_pin_o,
	input wire logic        sync_rising_o,
	input wire logic        rx_int_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	// ==========================================
	// mirror of the polarity bit
	logic pol;
	wire  mapped;
	assign mapped = addr_i == ADDR_RX_STATUS || addr_i == ADDR_RX_DATA || addr_i == ADDR_BAUD_CTRL;
	always_ff @(posedge clock_i) begin
		if (!rstn_i) pol <= 1'b0;
		else if (wr_i && addr_i == ADDR_BAUD_CTRL) pol <= wdata_i[BC_POL];
	end
	// ==========================================
	// steps of a status write then status read
	sequence s_port_off; wr_i && addr_i == ADDR_RX_STATUS && !wdata_i[RS_PORT_EN]; endsequence
	sequence s_rx_off; wr_i && addr_i == ADDR_RX_STATUS && !wdata_i[RS_RX_EN]; endsequence
	sequence s_stat_rd; rd_i && addr_i == ADDR_RX_STATUS; endsequence
	a_rdata_quiet: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (rd_i && !mapped |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_baud_resv_zero: assert property (rd_i && addr_i == ADDR_BAUD_CTRL |=> !rdata_o[5] && !rdata_o[2])
		else $error("reserved baud bits not zero");
	a_status_gap_zero: assert property (s_stat_rd |=> !rdata_o[6])
		else $error("status bit 6 not zero");
	a_tx_polarity: assert property ($past(rstn_i) && !$past(sync_mode_i) |-> tx_pin_o == ($past(tx_data_i) ^ $past(pol)))
		else $error("transmit polarity wrong");
	a_sync_edge_sel: assert property ($past(rstn_i) && $past(sync_mode_i) |-> sync_rising_o == $past(pol))
		else $error("sync clock edge select wrong");
	a_port_off_flush: assert property (s_port_off ##2 s_stat_rd |=> rdata_o[2:1] == 2'b00)
		else $error("port disable left error flags");
	a_rx_off_overrun: assert property (s_rx_off ##2 s_stat_rd |=> !rdata_o[RS_OVERRUN])
		else $error("receive disable left overrun");
endmodule : urx_chk
bind urx_top urx_chk #(.BRG_W(BRG_W)) u_chk (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_pin_i(rx_pin_i),
	.sync_mode_i(sync_mode_i), .brg_div_i(brg_div_i), .tx_data_i(tx_data_i), .tx_pin_o(tx_pin_o),
	.sync_rising_o(sync_rising_o), .rx_int_o(rx_int_o));
`default_nettype wire

/* File: verification/urx_line_model.sv */
// urx_line_model: remote serial transmitter on the receive line
`timescale 1ns/1ps
`default_nettype none
module urx_line_model (
	// clock
	input  wire logic clock_i,
	// serial line, idle high
	output var  logic line_o
);
	initial line_o = 1'b1;
	// one level held for n clocks
	task automatic bit_time(input logic v, input int n);
		line_o <= v;
		repeat (n) @(posedge clock_i);
	endtask : bit_time
	// start, data lsb first, stop, then two idle bits
	task automatic send(input logic [8:0] d, input int nb, input logic stop, input int div);
		bit_time(1'b0, div + 1);
		for (int i = 0; i < nb; i++) bit_time(d[i], div + 1);
		bit_time(stop, div + 1);
		bit_time(1'b1, 2 * (div + 1));
	endtask : send
endmodule : urx_line_model
`default_nettype wire

/* File: verification/uart_receive_errors_and_baud_control_tb_top.sv */
// uart_receive_errors_and_baud_control_tb_top: self-checking bench for urx_top
`timescale 1ns/1ps
`default_nettype none
module uart_receive_errors_and_baud_control_tb_top;
	import urx_pkg::*;
	localparam int DIV = 7; // eight clocks a bit from the low byte
	logic        clock_i, rstn_i, wr_i, rd_i, sync_mode_i, tx_data_i, rd_q;
	logic        tx_pin_o, sync_rising_o, rx_int_o;
	logic [3:0]  addr_i;
	logic [7:0]  wdata_i, rdata_o, e, m;
	logic [7:0]  exp_q[$], msk_q[$];
	logic [15:0] brg_div_i;
	logic [8:0]  d [4];
	wire         rx_line;
	int          err_count, comparisons, cycles, seed;
	urx_line_model line_m (.clock_i(clock_i), .line_o(rx_line));
	urx_top uut (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .rx_pin_i(rx_line), .sync_mode_i(sync_mode_i),
		.brg_div_i(brg_div_i), .tx_data_i(tx_data_i), .tx_pin_o(tx_pin_o),
		.sync_rising_o(sync_rising_o), .rx_int_o(rx_int_o));
	// ==========================================
	// clock, random transmit data, timeout
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		tx_data_i <= 1'($random(seed));
		rd_q <= rd_i;
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			finish_test();
		end
	end
	// read data checked against the oldest note
	always @(negedge clock_i) begin
		if (rd_q) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			comparisons++;
			if ((rdata_o & m) !== (e & m)) begin
				err_count++;
				$display("[FAIL] rdata expected %h seen %h", e & m, rdata_o & m);
			end
		end
	end
	// ==========================================
	// bus tasks and checks
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] ev, input logic [7:0] mv);
		@(posedge clock_i);
		exp_q.push_back(ev);
		msk_q.push_back(mv);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
	endtask : rd
	task automatic chk_int(input logic ev);
		repeat (3) @(posedge clock_i);
		@(negedge clock_i);
		comparisons++;
		if (rx_int_o !== ev) begin
			err_count++;
			$display("[FAIL] rx_int expected %b seen %b", ev, rx_int_o);
		end
	endtask : chk_int
	task automatic finish_test;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : finish_test
	// ==========================================
	// main sequence
	initial begin
		seed = 69;
		{rstn_i, wr_i, rd_i, rd_q, sync_mode_i, tx_data_i, addr_i, wdata_i} = '0;
		brg_div_i = 16'h0107;
		repeat (8) @(posedge clock_i);
		rstn_i <= 1'b1;
		repeat (6) @(posedge clock_i);
		rd(ADDR_BAUD_CTRL, 8'h40, 8'hFF);
		rd(4'h2, 8'h00, 8'hFF);
		wr(ADDR_RX_STATUS, 8'h90);
		// framing status travels with each character
		for (int i = 0; i < 2; i++) begin
			d[i] = 9'($random(seed));
			line_m.send(d[i], 8, i == 0, DIV);
		end
		chk_int(1'b1);
		rd(ADDR_RX_STATUS, 8'h00, 8'h04);
		rd(ADDR_RX_DATA, d[0][7:0], 8'hFF);
		rd(ADDR_RX_STATUS, 8'h04, 8'h04);
		rd(ADDR_RX_DATA, d[1][7:0], 8'hFF);
		chk_int(1'b0);
		// third character overruns, fourth refused
		for (int i = 0; i < 4; i++) begin
			d[i] = 9'($random(seed));
			line_m.send(d[i], 8, 1'b1, DIV);
		end
		rd(ADDR_RX_STATUS, 8'h02, 8'h02);
		rd(ADDR_RX_DATA, d[0][7:0], 8'hFF);
		rd(ADDR_RX_DATA, d[1][7:0], 8'hFF);
		chk_int(1'b0);
		wr(ADDR_RX_STATUS, 8'h80);
		rd(ADDR_RX_STATUS, 8'h80, 8'hFF);
		// receive disable keeps framing, port disable clears it
		wr(ADDR_RX_STATUS, 8'h90);
		line_m.send(9'h0E7, 8, 1'b0, DIV);
		chk_int(1'b1);
		wr(ADDR_RX_STATUS, 8'h80);
		rd(ADDR_RX_STATUS, 8'h84, 8'hFE);
		wr(ADDR_RX_STATUS, 8'h00);
		rd(ADDR_RX_STATUS, 8'h00, 8'hFF);
		// nine-bit characters and address detect
		wr(ADDR_RX_STATUS, 8'hB0);
		line_m.send(9'h1A5, 9, 1'b1, DIV);
		rd(ADDR_RX_STATUS, 8'h01, 8'h07);
		rd(ADDR_RX_DATA, 8'hA5, 8'hFF);
		wr(ADDR_RX_STATUS, 8'hB8);
		line_m.send(9'h05A, 9, 1'b1, DIV);
		chk_int(1'b0);
		line_m.send(9'h1C3, 9, 1'b1, DIV);
		chk_int(1'b1);
		wr(ADDR_RX_STATUS, 8'hB0);
		line_m.send(9'h03C, 9, 1'b1, DIV);
		rd(ADDR_RX_STATUS, 8'h01, 8'h01);
		rd(ADDR_RX_DATA, 8'hC3, 8'hFF);
		rd(ADDR_RX_STATUS, 8'h00, 8'h01);
		rd(ADDR_RX_DATA, 8'h3C, 8'hFF);
		// baud control fields, wide generator uses the full divisor
		wr(ADDR_RX_STATUS, 8'h90);
		wr(ADDR_BAUD_CTRL, 8'h3C);
		rd(ADDR_BAUD_CTRL, 8'h58, 8'hFF);
		d[0] = 9'($random(seed));
		line_m.send(d[0], 8, 1'b1, 263);
		rd(ADDR_RX_DATA, d[0][7:0], 8'hFF);
		for (int p = 0; p < 2; p++) begin
			wr(ADDR_BAUD_CTRL, p ? 8'h10 : 8'h00);
			sync_mode_i <= 1'b1;
			repeat (8) @(posedge clock_i);
			sync_mode_i <= 1'b0;
			repeat (8) @(posedge clock_i);
		end
		// wake and autobaud clear themselves
		wr(ADDR_BAUD_CTRL, 8'h02);
		line_m.bit_time(1'b0, 8);
		line_m.bit_time(1'b1, 120);
		rd(ADDR_BAUD_CTRL, 8'h00, 8'h02);
		wr(ADDR_BAUD_CTRL, 8'h01);
		line_m.bit_time(1'b0, 20);
		line_m.bit_time(1'b1, 20);
		rd(ADDR_BAUD_CTRL, 8'h00, 8'h81);
		wr(ADDR_RX_STATUS, 8'h00);
		rd(ADDR_RX_STATUS, 8'h00, 8'hFF);
		repeat (4) @(posedge clock_i);
		finish_test();
	end
endmodule : uart_receive_errors_and_baud_control_tb_top
`default_nettype wire
